// file: hw/clock_block.sv
// One programmable clock block: divides the reference or a pin clock.
// Assumes src_lvl is already synchronised to sys_clk.
`timescale 1ns/100ps
module clock_block (
    input  wire logic                       sys_clk,  // Reference clock
    input  wire logic                       rst,      // Async reset
    input  wire logic                       src_lvl,  // Filtered pin clock
    input  wire rport_pkg::cbcfg_t          cfg,      // Source and divider
    output logic                            tick      // Rate enable pulse
);
    import rport_pkg::*;

    typedef struct packed {
        logic            prev;
        logic [DIVW-1:0] cnt;
        logic            tick;
    } cb_state_t;

    cb_state_t s;
    cb_state_t next_s;

    always_comb begin
        logic src_edge;
        src_edge = 1'b0;
        next_s = s;
        next_s.prev = src_lvl;
        next_s.tick = 1'b0;
        // Pin source counts rising edges only
        src_edge = cfg.pin ? (src_lvl & ~s.prev) : 1'b1;
        if (src_edge) begin
            if (s.cnt >= cfg.div) begin
                next_s.cnt = '0;
                next_s.tick = 1'b1;
            end else begin
                next_s.cnt = s.cnt + 1'b1;
            end
        end
    end

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            s <= '0;
        end else begin
            s <= next_s;
        end
    end

    assign tick = s.tick;

endmodule // clock_block

// file: hw/response_port_tile.sv
// Pin-facing ports with timing counters and six clock blocks.
// Assumes an Avalon-MM master; pins resolved outside from pin_oe_n.
//
// Functional notes
// - Ports of fixed widths on overlapping pins.
// - One direction for all pins of port.
// - Drive pins, or sample with optional condition.
// - Each access completes after one wait state.
// - Open collector drives zero, floats one.
// - Open collector chosen per port.
// - Shift serializer plus transfer register buffer.
// - Sixteen-bit counter times each transfer.
// - Counter readable; future count delays transfer.
// - Counter captured as timestamp per transfer.
// - Enabled link takes its shared pins.
// - Narrower enabled port beats wider port.
// - Unshared wide pins stay with wide port.
// - Transfers always at full port width.
// - Six clock blocks; block zero is reference.
// - Other clock blocks run own rates.
// - Clock block may use pin clock.
// - Pin clock optionally divided.
// - Incoming ready strobe gates sampling.
// - Outgoing strobe marks valid output data.
// - Ports start on clock block zero.
`timescale 1ns/100ps
module response_port_tile #(
    parameter int               NW        = 4,
    parameter int               WW        = 8,
    parameter int               NPIN      = 8,
    parameter logic [NPIN-1:0]  LINK_MASK = 8'hC0
) (
    input  wire logic                     sys_clk,     // 10 MHz clock
    input  wire logic                     rst,         // Async reset
    input  wire logic [rport_pkg::AW-1:0] address,     // Byte address
    input  wire logic                     read,        // Read request
    input  wire logic                     write,       // Write request
    input  wire logic [3:0]               byteenable,  // Write lanes
    input  wire logic [rport_pkg::DW-1:0] writedata,   // Write data
    output logic      [rport_pkg::DW-1:0] readdata,    // Read data
    output logic                          waitrequest, // Slave stall
    input  wire logic [NPIN-1:0]          pin_in,      // Pin levels
    output logic      [NPIN-1:0]          pin_out,     // Pin drive values
    output logic      [NPIN-1:0]          pin_oe_n,    // Low while driving
    input  wire logic                     app_clk_pin, // 1-bit clock port
    input  wire logic [rport_pkg::NPORT-1:0] ready_in,  // Incoming strobes
    output logic      [rport_pkg::NPORT-1:0] strobe_out,// Outgoing strobes
    output logic      [rport_pkg::NPORT-1:0] port_event // Scheduler events
);
    import rport_pkg::*;

    localparam int NSYNC = NPIN + NPORT + 1;

    typedef struct packed {
        pstate_t [NPORT-1:0]    p;
        cbcfg_t  [CB_N-1:1]     cb;
        logic                   link_en;
        logic                   ack;
        logic [DW-1:0]          rdata;
        logic [NPORT-1:0]       evt;
        logic [2:0][NSYNC-1:0]  sy;
        logic [NSYNC-1:0]       sf;
        logic [NPIN-1:0]        pout;
        logic [NPIN-1:0]        poe_n;
    } top_state_t;

    top_state_t s;
    top_state_t next_s;

    logic [CB_N-1:0] cb_tick;

    function automatic int pw(input int p);
        return (p == 0) ? NW : WW;
    endfunction

    function automatic logic [DW-1:0] wmask(input int p);
        return {DW{1'b1}} >> (DW - pw(p));
    endfunction

    function automatic logic [DW-1:0] be_merge(
        input logic [DW-1:0] old,
        input logic [DW-1:0] wd,
        input logic [3:0]    be
    );
        logic [DW-1:0] r;
        r = old;
        for (int b = 0; b < 4; b++) begin
            if (be[b]) begin
                r[b*8 +: 8] = wd[b*8 +: 8];
            end
        end
        return r;
    endfunction

    // Block zero is the reference rate itself
    assign cb_tick[0] = 1'b1;

    for (genvar g = 1; g < CB_N; g++) begin : g_cb
        clock_block u_cb (
            .sys_clk (sys_clk),
            .rst     (rst),
            .src_lvl (s.sf[NSYNC-1]),
            .cfg     (s.cb[g]),
            .tick    (cb_tick[g])
        );
    end

    always_comb begin
        logic [NPIN-1:0]  pins;
        logic [NPORT-1:0] rdy;
        logic [DW-1:0]    pv;
        logic [DW-1:0]    sh;
        logic [DW-1:0]    wd;
        logic [NPORT-1:0] set_full;
        logic             tick;
        logic             tok;
        logic             cok;
        logic             drv;
        logic             val;
        logic [2:0]       pidx;
        logic [4:0]       off;
        int               w;
        int               ci;
        pins = '0;
        rdy = '0;
        pv = '0;
        sh = '0;
        wd = '0;
        set_full = '0;
        tick = 1'b0;
        tok = 1'b0;
        cok = 1'b0;
        drv = 1'b0;
        val = 1'b0;
        w = 0;
        ci = 0;
        pidx = address[AW-1:PORT_SHIFT];
        off = address[PORT_SHIFT-1:0];
        next_s = s;
        next_s.evt = '0;

        // Bus answers after one wait state
        next_s.ack = (read | write) & ~s.ack;

        // Three-stage pin synchroniser, change needs stages two and three
        next_s.sy = {s.sy[1:0], {app_clk_pin, ready_in, pin_in}};
        next_s.sf = (s.sy[1] & s.sy[2]) | (s.sf & (s.sy[1] | s.sy[2]));
        pins = s.sf[NPIN-1:0];
        rdy = s.sf[NPIN +: NPORT];

        for (int p = 0; p < NPORT; p++) begin
            w = pw(p);
            tick = (s.p[p].cfg.cb < 3'(CB_N)) ? cb_tick[s.p[p].cfg.cb] : 1'b0;
            pv = DW'(pins) & wmask(p);
            // Counter follows its clock block even while the port is off
            if (tick) begin
                next_s.p[p].count = s.p[p].count + 1'b1;
            end
            if (tick && s.p[p].cfg.en) begin
                tok = !s.p[p].time_vld || (s.p[p].count == s.p[p].time_at);
                if (s.p[p].cfg.out) begin
                    next_s.p[p].strobe = 1'b0;
                    if (s.p[p].cnt == '0) begin
                        if (s.p[p].full && tok) begin
                            next_s.p[p].out_bits = s.p[p].xfer & wmask(p);
                            next_s.p[p].shift = s.p[p].xfer >> w;
                            next_s.p[p].cnt = CNTW'(DW / w - 1);
                            next_s.p[p].full = 1'b0;
                            next_s.p[p].strobe = s.p[p].cfg.sout;
                            next_s.p[p].stamp = s.p[p].count;
                            next_s.p[p].time_vld = 1'b0;
                            next_s.evt[p] = 1'b1;
                        end
                    end else begin
                        next_s.p[p].out_bits = s.p[p].shift & wmask(p);
                        next_s.p[p].shift = s.p[p].shift >> w;
                        next_s.p[p].cnt = s.p[p].cnt - 1'b1;
                        next_s.p[p].strobe = s.p[p].cfg.sout;
                    end
                end else begin
                    unique case (s.p[p].cfg.cond)
                        COND_NONE: cok = 1'b1;
                        COND_EQ:   cok = (pv == (s.p[p].cond_val & wmask(p)));
                        COND_NE:   cok = (pv != (s.p[p].cond_val & wmask(p)));
                        default:   cok = 1'b1;
                    endcase
                    if (tok && cok && (!s.p[p].cfg.sin || rdy[p])) begin
                        sh = (s.p[p].shift >> w) | (pv << (DW - w));
                        next_s.p[p].shift = sh;
                        if (int'(s.p[p].cnt) + 1 >= DW / w) begin
                            next_s.p[p].xfer = sh;
                            next_s.p[p].full = 1'b1;
                            set_full[p] = 1'b1;
                            next_s.p[p].cnt = '0;
                            next_s.p[p].stamp = s.p[p].count;
                            next_s.p[p].time_vld = 1'b0;
                            next_s.evt[p] = 1'b1;
                        end else begin
                            next_s.p[p].cnt = s.p[p].cnt + 1'b1;
                        end
                    end
                end
            end
        end

        // Register access; read data stands until the next read
        if (read && !s.ack) begin
            next_s.rdata = '0;
            if (int'(pidx) < NPORT) begin
                unique case (off)
                    R_CTRL:  next_s.rdata = DW'(s.p[pidx].cfg);
                    R_DATA:  next_s.rdata = s.p[pidx].xfer;
                    R_COND:  next_s.rdata = s.p[pidx].cond_val;
                    R_TIME:  next_s.rdata = DW'(s.p[pidx].time_at);
                    R_COUNT: next_s.rdata = DW'(s.p[pidx].count);
                    R_STAMP: next_s.rdata = DW'(s.p[pidx].stamp);
                    R_STAT:  next_s.rdata = DW'({s.p[pidx].cnt, s.p[pidx].time_vld,
                                                 s.p[pidx].full});
                    default: next_s.rdata = '0;
                endcase
            end else if (address == R_LINK) begin
                next_s.rdata = DW'(s.link_en);
            end else if (address[AW-1:PORT_SHIFT] == R_CB_BASE[AW-1:PORT_SHIFT]) begin
                ci = int'(address[PORT_SHIFT-1:WORD_SHIFT]);
                if (ci >= 1 && ci < CB_N) begin
                    next_s.rdata = DW'(s.cb[ci]);
                end
            end
        end

        if (read && s.ack && int'(pidx) < NPORT && off == R_DATA) begin
            for (int p = 0; p < NPORT; p++) begin
                // A capture in the same cycle keeps the word pending
                if (p == int'(pidx) && !s.p[p].cfg.out && !set_full[p]) begin
                    next_s.p[p].full = 1'b0;
                end
            end
        end

        if (write && s.ack) begin
            if (int'(pidx) < NPORT) begin
                for (int p = 0; p < NPORT; p++) begin
                    if (p == int'(pidx)) begin
                        unique case (off)
                            R_CTRL: begin
                                wd = be_merge(DW'(s.p[p].cfg), writedata, byteenable);
                                next_s.p[p].cfg = pcfg_t'(wd[PCFG_W-1:0]);
                            end
                            R_DATA: begin
                                next_s.p[p].xfer = be_merge(s.p[p].xfer, writedata, byteenable);
                                next_s.p[p].full = 1'b1;
                            end
                            R_COND: begin
                                next_s.p[p].cond_val = be_merge(s.p[p].cond_val, writedata, byteenable);
                            end
                            R_TIME: begin
                                wd = be_merge(DW'(s.p[p].time_at), writedata, byteenable);
                                next_s.p[p].time_at = wd[CW-1:0];
                                next_s.p[p].time_vld = 1'b1;
                            end
                            default: ;
                        endcase
                    end
                end
            end else if (address == R_LINK) begin
                if (byteenable[0]) begin
                    next_s.link_en = writedata[0];
                end
            end else if (address[AW-1:PORT_SHIFT] == R_CB_BASE[AW-1:PORT_SHIFT]) begin
                ci = int'(address[PORT_SHIFT-1:WORD_SHIFT]);
                for (int c = 1; c < CB_N; c++) begin
                    if (c == ci) begin
                        wd = be_merge(DW'(s.cb[c]), writedata, byteenable);
                        next_s.cb[c] = cbcfg_t'(wd[CBCFG_W-1:0]);
                    end
                end
            end
        end

        // Pin ownership and drive
        for (int i = 0; i < NPIN; i++) begin
            drv = 1'b0;
            val = 1'b0;
            if (i < NW && next_s.p[0].cfg.en) begin
                drv = next_s.p[0].cfg.out;
                val = next_s.p[0].out_bits[i];
                if (next_s.p[0].cfg.oc) begin
                    drv = drv & ~val;
                end
            end else if (i < WW && next_s.p[1].cfg.en) begin
                drv = next_s.p[1].cfg.out;
                val = next_s.p[1].out_bits[i];
                if (next_s.p[1].cfg.oc) begin
                    drv = drv & ~val;
                end
            end
            if (next_s.link_en && LINK_MASK[i]) begin
                drv = 1'b0;
            end
            next_s.pout[i] = drv & val;
            next_s.poe_n[i] = ~drv;
        end
    end

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            s <= '0;
            s.poe_n <= '1;
            for (int p = 0; p < NPORT; p++) begin
                s.p[p].cfg.cb <= CB_REF;
            end
        end else begin
            s <= next_s;
        end
    end

    assign waitrequest = (read | write) & ~s.ack;
    assign readdata = s.rdata;
    assign pin_out = s.pout;
    assign pin_oe_n = s.poe_n;
    assign port_event = s.evt;

    for (genvar g = 0; g < NPORT; g++) begin : g_strobe
        assign strobe_out[g] = s.p[g].strobe;
    end

endmodule // response_port_tile

// file: inc/rport_pkg.sv
// Shared constants and types for the pin port tile.
// Assumes a byte-addressed Avalon-MM slave with 32-bit data.
package rport_pkg;

    localparam int NPORT = 2;
    localparam int CB_N  = 6;
    localparam int DW    = 32;
    localparam int CW    = 16;
    localparam int AW    = 8;
    localparam int DIVW  = 8;
    localparam int CNTW  = 6;

    // Register map, byte addresses
    localparam logic [2:0] PORT_IDX_LO = 3'h0;
    localparam logic [4:0] R_CTRL      = 5'h00;
    localparam logic [4:0] R_DATA      = 5'h04;
    localparam logic [4:0] R_COND      = 5'h08;
    localparam logic [4:0] R_TIME      = 5'h0C;
    localparam logic [4:0] R_COUNT     = 5'h10;
    localparam logic [4:0] R_STAMP     = 5'h14;
    localparam logic [4:0] R_STAT      = 5'h18;
    localparam logic [7:0] R_LINK      = 8'h40;
    localparam logic [7:0] R_CB_BASE   = 8'h80;
    localparam int         PORT_SHIFT  = 5;
    localparam int         WORD_SHIFT  = 2;

    localparam logic [2:0] CB_REF      = 3'h0;

    typedef enum logic [1:0] {
        COND_NONE = 2'b00,
        COND_EQ   = 2'b01,
        COND_NE   = 2'b10
    } cond_t;

    typedef struct packed {
        logic       en;
        logic       out;
        logic       oc;
        logic       sin;
        logic       sout;
        cond_t      cond;
        logic [2:0] cb;
    } pcfg_t;

    localparam int PCFG_W = $bits(pcfg_t);

    typedef struct packed {
        pcfg_t           cfg;
        logic [DW-1:0]   cond_val;
        logic [DW-1:0]   xfer;
        logic [DW-1:0]   shift;
        logic [DW-1:0]   out_bits;
        logic            full;
        logic [CNTW-1:0] cnt;
        logic [CW-1:0]   count;
        logic [CW-1:0]   stamp;
        logic [CW-1:0]   time_at;
        logic            time_vld;
        logic            strobe;
    } pstate_t;

    typedef struct packed {
        logic            pin;
        logic [DIVW-1:0] div;
    } cbcfg_t;

    localparam int CBCFG_W = $bits(cbcfg_t);

endpackage

// file: testbench/pin_partner.sv
// External hardware on the tile pins: resolver, clock source, slice log.
// Assumes pull-downs on pins that nobody drives.
`timescale 1ns/100ps
module pin_partner (
    input  wire logic       sys_clk,     // Tile clock for logging
    input  wire logic [7:0] pin_out,     // Tile drive values
    input  wire logic [7:0] pin_oe_n,    // Tile enables, low drives
    input  wire logic [1:0] strobe_out,  // Tile strobes
    output logic      [7:0] pin_in,      // Resolved pin levels
    output logic            app_clk_pin, // Application clock
    output logic      [1:0] ready_in     // Ready strobes to tile
);
    logic [7:0]  ext_drv;
    logic [7:0]  ext_en;
    logic [15:0] log_q[$];

    initial begin
        ext_drv = 8'h00;
        ext_en = 8'h00;
        app_clk_pin = 1'b0;
        ready_in = 2'b00;
    end
    // Drives only pins the tile has released
    always_comb pin_in = (~pin_oe_n & pin_out) | (pin_oe_n & ext_en & ext_drv);
    // Enables and levels seen with each wide strobe
    always @(posedge sys_clk) if (strobe_out[1]) log_q.push_back({pin_oe_n, pin_in});
    // Clock stands low between bursts
    task automatic clk_burst(input int n);
        @(negedge sys_clk);
        repeat (n) begin
            #400 app_clk_pin = 1'b1;
            #400 app_clk_pin = 1'b0;
        end
    endtask
endmodule // pin_partner

// file: testbench/response_port_tile_props.sv
// Bus, pin and event properties of the pin port tile.
// Assumes it is bound onto response_port_tile and sees only its ports.
`timescale 1ns/100ps
module response_port_tile_props
    import rport_pkg::*;
#(
    parameter int              NW        = 4,
    parameter int              WW        = 8,
    parameter int              NPIN      = 8,
    parameter logic [NPIN-1:0] LINK_MASK = 8'hC0
) (
    input wire logic                        sys_clk,     // Clock
    input wire logic                        rst,         // Async reset
    input wire logic [rport_pkg::AW-1:0]    address,     // Byte address
    input wire logic                        read,        // Read request
    input wire logic                        write,       // Write request
    input wire logic [3:0]                  byteenable,  // Write lanes
    input wire logic [rport_pkg::DW-1:0]    writedata,   // Write data
    input wire logic [rport_pkg::DW-1:0]    readdata,    // Read data
    input wire logic                        waitrequest, // Slave stall
    input wire logic [NPIN-1:0]             pin_in,      // Pin levels
    input wire logic [NPIN-1:0]             pin_out,     // Drive values
    input wire logic [NPIN-1:0]             pin_oe_n,    // Low drives
    input wire logic                        app_clk_pin, // Pin clock
    input wire logic [rport_pkg::NPORT-1:0] ready_in,    // Ready in
    input wire logic [rport_pkg::NPORT-1:0] strobe_out,  // Strobes out
    input wire logic [rport_pkg::NPORT-1:0] port_event   // Events
);
    default clocking cb_main @(posedge sys_clk); endclocking
    default disable iff (rst);

    sequence s_one_wait;
        waitrequest ##1 !waitrequest;
    endsequence

    a_first_stall: assert property ($rose(read || write) |-> s_one_wait)
        else $error("request not answered after one wait state");
    a_wait_once: assert property ((read || write) && waitrequest |=> !waitrequest)
        else $error("second wait state seen");
    a_idle_ready: assert property (!(read || write) |-> !waitrequest)
        else $error("stall without request");
    a_read_hold: assert property (!(read && waitrequest) |=> $stable(readdata))
        else $error("read data moved without a read");
    a_undriven_low: assert property ((pin_out & pin_oe_n) == '0)
        else $error("drive value high on released pin");
    a_narrow_gap: assert property (port_event[0] |=> !port_event[0] [*7])
        else $error("narrow word shorter than full width");
    a_wide_gap: assert property (port_event[1] |=> !port_event[1] [*3])
        else $error("wide word shorter than full width");
    a_reset_quiet: assert property (disable iff (1'b0) rst |-> &pin_oe_n && strobe_out == '0 && port_event == '0)
        else $error("pins or strobes active in reset");
endmodule // response_port_tile_props

bind response_port_tile response_port_tile_props #(.NW(NW), .WW(WW), .NPIN(NPIN), .LINK_MASK(LINK_MASK))
    response_port_tile_props_i (.sys_clk(sys_clk), .rst(rst), .address(address), .read(read), .write(write),
    .byteenable(byteenable), .writedata(writedata), .readdata(readdata), .waitrequest(waitrequest),
    .pin_in(pin_in), .pin_out(pin_out), .pin_oe_n(pin_oe_n), .app_clk_pin(app_clk_pin),
    .ready_in(ready_in), .strobe_out(strobe_out), .port_event(port_event));

// file: testbench/tb.sv
// Self-checking bench for the pin port tile over its register bus.
// Assumes the one-wait-state bus and the pin partner model.
`timescale 1ns/100ps
`define CHK(got, exp) begin samples_checked++; if ((got) !== (exp)) begin err_count++; \
    $display("MISMATCH t=%0t got %h exp %h", $time, got, exp); end end
module tb;
    import rport_pkg::*;
    logic          sys_clk, rst, read, write, waitrequest, app_clk_pin;
    logic [AW-1:0] address;
    logic [3:0]    byteenable;
    logic [DW-1:0] writedata, readdata, rd, c;
    logic [7:0]    pin_in, pin_out, pin_oe_n, mask, sl, oe;
    logic [1:0]    ready_in, strobe_out, port_event;
    logic [15:0]   t;
    int            err_count, samples_checked, cycles, ev1, e;
    logic [31:0]   tab_d[3] = '{32'h87654321, 32'h0FF05AA5, 32'h12345678};
    logic [9:0]    tab_c[3] = '{10'h320, 10'h3A0, 10'h320};

    response_port_tile #(.NW(4), .WW(8), .NPIN(8), .LINK_MASK(8'hC0)) response_port_tile_i (
        .sys_clk(sys_clk), .rst(rst), .address(address), .read(read), .write(write),
        .byteenable(byteenable), .writedata(writedata), .readdata(readdata), .waitrequest(waitrequest),
        .pin_in(pin_in), .pin_out(pin_out), .pin_oe_n(pin_oe_n), .app_clk_pin(app_clk_pin),
        .ready_in(ready_in), .strobe_out(strobe_out), .port_event(port_event));
    pin_partner pin_partner_i (.sys_clk(sys_clk), .pin_out(pin_out), .pin_oe_n(pin_oe_n),
        .strobe_out(strobe_out), .pin_in(pin_in), .app_clk_pin(app_clk_pin), .ready_in(ready_in));

    initial begin
        sys_clk = 1'b0;
        forever #50 sys_clk = ~sys_clk;
    end

    task automatic conclude;
        $display("checks %0d mismatches %0d", samples_checked, err_count);
        if (err_count == 0 && samples_checked > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask

    always @(posedge sys_clk) begin
        cycles++;
        ev1 += int'(port_event[1]);
        if (cycles == 5000) begin
            err_count++;
            conclude();
        end
    end

    // Holds the request until a rising edge with waitrequest low; caller releases
    task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
        read <= !wr;
        write <= wr;
        address <= a;
        writedata <= d;
        byteenable <= 4'hF;
        do begin
            @(posedge sys_clk);
        end while (waitrequest !== 1'b0);
        rd = readdata;
    endtask

    task automatic wt(input int n);
        read <= 1'b0;
        write <= 1'b0;
        repeat (n + 1) @(posedge sys_clk);
    endtask

    initial begin
        rst <= 1'b1;
        {read, write, address, byteenable, writedata, rd} = '0;
        {err_count, samples_checked, cycles, ev1} = '0;
        repeat (2) @(posedge sys_clk);
        rst <= 1'b0;
        @(negedge sys_clk);
        `CHK(pin_oe_n, 8'hFF)
        @(posedge sys_clk);
        bus(0, 8'h20, 0);
        `CHK(rd, 32'h0)
        bus(0, 8'h3C, 0);
        `CHK(rd, 32'h0)
        bus(0, 8'h30, 0);
        c = rd;
        bus(0, 8'h30, 0);
        `CHK(rd[15:0], c[15:0] + 16'd2)
        $display("test reset and counter done");
        for (int k = 0; k < 3; k++) begin
            mask = 8'hFF;
            if (k == 2) begin
                bus(1, 8'h00, 32'h200);
                bus(1, R_LINK, 32'h1);
                mask = 8'h30;
            end
            pin_partner_i.log_q.delete();
            e = ev1;
            bus(1, 8'h20, {22'h0, tab_c[k]});
            bus(1, 8'h24, tab_d[k]);
            wt(20);
            `CHK(pin_partner_i.log_q.size(), 4)
            `CHK(ev1 - e, 1)
            for (int s = 0; s < 4 && s < pin_partner_i.log_q.size(); s++) begin
                sl = tab_d[k][8*s +: 8];
                oe = tab_c[k][7] ? ~(mask & ~sl) : ~mask;
                `CHK(pin_partner_i.log_q[s][15:8], oe)
                `CHK(pin_partner_i.log_q[s][7:0] & ~oe, sl & ~oe)
            end
            $display("test wide output %0d done", k);
        end
        bus(1, R_LINK, 32'h0);
        bus(1, 8'h20, 32'h300);
        bus(0, 8'h30, 0);
        t = rd[15:0] + 16'd40;
        bus(1, 8'h2C, {16'h0, t});
        bus(1, 8'h24, 32'hA5A5A5A5);
        wt(10);
        bus(0, 8'h38, 0);
        `CHK(rd[1:0], 2'b11)
        wt(50);
        bus(0, 8'h34, 0);
        `CHK(rd[15:0], t)
        bus(0, 8'h38, 0);
        `CHK(rd[1:0], 2'b00)
        $display("test timed output done");
        pin_partner_i.ext_en <= 8'h0F;
        pin_partner_i.ext_drv <= 8'h05;
        pin_partner_i.ready_in <= 2'b01;
        bus(1, 8'h08, 32'h5);
        for (int m = 0; m < 4; m++) begin
            bus(1, 8'h00, 32'h240 | (m << 3));
            wt(20);
            bus(0, 8'h18, 0);
            `CHK(rd[0], m != 2)
            bus(1, 8'h00, 32'h0);
            bus(0, 8'h04, 0);
            if (m != 2) `CHK(rd, 32'h55555555)
        end
        pin_partner_i.ready_in <= 2'b00;
        wt(3);
        bus(1, 8'h00, 32'h240);
        bus(0, 8'h18, 0);
        c = rd;
        wt(20);
        bus(0, 8'h18, 0);
        `CHK(rd, c)
        `CHK(rd[0], 1'b0)
        pin_partner_i.ready_in <= 2'b01;
        wt(20);
        bus(0, 8'h18, 0);
        `CHK(rd[0], 1'b1)
        $display("test input conditions done");
        bus(1, 8'h84, 32'h101);
        bus(1, 8'h00, 32'h201);
        bus(0, 8'h10, 0);
        c = rd;
        wt(2);
        pin_partner_i.clk_burst(6);
        wt(10);
        bus(0, 8'h10, 0);
        `CHK(rd[15:0], c[15:0] + 16'd3)
        wt(2);
        $display("test pin clock done");
        conclude();
    end
endmodule // tb
